// >>> core/rhc_pkg.sv
package rhc_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] RHC_CTRL_OFS    = 8'h00;
  localparam logic [7:0] RHC_STAT_OFS    = 8'h04;
  localparam logic [7:0] RHC_AR_OFS      = 8'h08;
  localparam logic [7:0] RHC_PC_OFS      = 8'h0C;
  localparam logic [7:0] RHC_VMA_OFS     = 8'h10;
  localparam logic [7:0] RHC_MQ_OFS      = 8'h14;
  localparam logic [7:0] RHC_ARX_OFS     = 8'h18;
  localparam logic [7:0] RHC_IOBUS_OFS   = 8'h1C;

  // ==========================================================================
  // Control register bit positions (write 1 = pulse unless noted)
  localparam int RHC_CB_RUN_SET   = 0;
  localparam int RHC_CB_RUN_CLR   = 1;
  localparam int RHC_CB_RESUME    = 2;
  localparam int RHC_CB_HALT_INS  = 3;
  localparam int RHC_CB_PRIV      = 4;   // Level: privileged mode
  localparam int RHC_CB_LOAD_CS   = 5;   // Microprogram loaded
  localparam int RHC_CB_DEC       = 6;   // Pulse: memory ack
  localparam int RHC_CB_IOACK     = 7;   // Pulse: io handshake done

  // ==========================================================================
  // Widths and constants
  localparam int          RHC_W          = 36;
  localparam int          RHC_AW         = 23;
  localparam logic [22:0] RHC_INTR_BASE  = 23'h000020; // Octal 40
  localparam logic [1:0]  RHC_SYNC_CYC   = 2'h3;
  localparam logic [3:0]  RHC_FN_STD0    = 4'h0;
  localparam logic [3:0]  RHC_FN_STD1    = 4'h1;
  localparam logic [3:0]  RHC_FN_DISP    = 4'h2;
  localparam logic [3:0]  RHC_FN_INCDEC  = 4'h3;
  localparam logic [3:0]  RHC_FN_DOUT    = 4'h4;
  localparam logic [3:0]  RHC_FN_DIN     = 4'h5;
  localparam logic [3:0]  RHC_FN_FRONT   = 4'h6;
  localparam int          RHC_FN_LSB     = 32;  // Code in top 4 bits
  localparam int          RHC_DEC_BIT    = 31;  // 1 = decrement
  localparam int          RHC_CH_LSB     = 23;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [4:0] {
    RHC_DIAG, RHC_DISPATCH, RHC_HALT_ENTER, RHC_TIGHT, RHC_INTR_WAIT,
    RHC_INTR_DECODE, RHC_FETCH, RHC_RD, RHC_WR, RHC_IO_OUT, RHC_IO_IN,
    RHC_NEXT_REQ, RHC_NOOP, RHC_EXEC, RHC_FRONT
  } rhc_state_t;

endpackage : rhc_pkg

// >>> core/rhc_core.sv
// How it works
// - Cond/data in loads arith_reg from bus; outs drive adder output.
// - Interrupt work starts only after word held and handshake done.
// - Copy word to mult_quot_reg; dispatch on shift_matrix bits 00-03.
// - Codes 0/1 fetch from address 40 + 2n, channel n 1-7.
// - Standard interrupt fetch asserts executive-table qualifier.
// - Code 2 fetches device virtual address, no qualifier, into ext reg.
// - Increment/decrement reads word, adds or subtracts one, writes back.
// - Code 4 reads then outputs word; code 5 inputs word then stores.
// - Code 6 alone reserved for front-end examine/deposit/byte transfers.
// - Reset clears control store; zero dispatch means diagnostic state.
// - Halt loop entered at dispatch when run and intr cycle are clear.
// - Continue sets continue_sync for exactly three clocks.
// - instr_go_flag set by continue, held until halt instruction.
// - run_state is run source and instr_go_flag both true.
// - Halt entry clears arith_reg, sets halt, swaps counter and address.
// - Halted with interrupt: service; codes 0-2 fetch and execute, other codes take next request, no-op, clear; then redispatch.
// - Halted without interrupt: loop testing start and interrupt requests.
// - Halt clears only instr_go_flag, and only in privileged modes.
// - Run clear drops run source; tight loop at next dispatch.
// - Nonzero arith_reg on resume executes with counter advance blocked.
// - Zero arith_reg on resume fetches at counter, executes, advances.
// - Interrupts sampled only at next-instruction dispatch and in the halt loop.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
module rhc_core import rhc_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // I/O bus
  input  wire logic              intr_req,
  input  wire logic [RHC_W-1:0]  io_bus_in,
  output logic [RHC_W-1:0]       io_bus_out,
  output logic                   io_bus_oe,
  // Memory control unit
  input  wire logic [RHC_W-1:0]  mem_rdata,
  output logic                   mem_req,
  output logic                   mem_write,
  output logic                   mem_exec_table,
  output logic [RHC_AW-1:0]      mem_addr,
  output logic [RHC_W-1:0]       mem_wdata,
  // Status
  output logic                   run_state,
  output logic                   continue_sync,
  output logic                   halt_flag
);

  // ==========================================================================
  // State
  typedef struct packed {
    rhc_state_t        st;
    logic              cs_loaded;
    logic              run_src;
    logic              instr_go;
    logic [1:0]        sync_cnt;
    logic              halt;
    logic              intr_cycle;
    logic              adv_block;
    logic              priv;
    logic              mem_ack;
    logic              io_ack;
    logic              io_oe;
    logic              wr_pend;
    logic              req;
    logic              wr;
    logic              exec_process_table;
    logic [RHC_AW-1:0] addr;
    logic [RHC_W-1:0]  wdata;
    logic [RHC_W-1:0]  ar;
    logic [RHC_W-1:0]  arith_ext_reg;
    logic [RHC_W-1:0]  mq;
    logic [RHC_W-1:0]  adder;
    logic [RHC_AW-1:0] pc;
    logic [RHC_AW-1:0] virt_addr_reg;
    logic [3:0]        fn;
    logic [7:0]        ad;
    logic [31:0]       rdata;
  } rhc_regs_t;

  rhc_regs_t r_q, r_d;

  function automatic logic [RHC_AW-1:0] vaddr(input logic [RHC_W-1:0] w);
    vaddr = w[RHC_AW-1:0];
  endfunction : vaddr

  function automatic logic [31:0] lo32(input logic [RHC_W-1:0] w);
    lo32 = w[31:0];
  endfunction : lo32

  // Shift matrix passes arith_reg straight; code is output bits 00-03
  logic [RHC_W-1:0] shift_matrix;
  logic [3:0]       sh_code;
  logic [2:0]       chan;
  logic             wr_now;
  assign shift_matrix = r_q.ar;
  assign sh_code      = shift_matrix[RHC_FN_LSB +: 4];
  assign chan         = r_q.ar[RHC_CH_LSB +: 3];
  assign wr_now = r_q.wr_pend;

  // ==========================================================================
  // Next state
  always_comb begin
    r_d = r_q;
    r_d.io_ack = 1'b0;
    // Memory ack is one cycle so a stale ack never ends the next request
    r_d.mem_ack = 1'b0;
    r_d.wr_pend = 1'b0;
    if (r_q.sync_cnt != 2'h0) begin
      r_d.sync_cnt = r_q.sync_cnt - 2'h1;
    end
    // Bus address phase
    if (hsel && hready && htrans[1]) begin
      r_d.ad      = haddr[7:0];
      r_d.wr_pend = hwrite;
    end
    // Read data latched at address phase so it stands in the data phase
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        RHC_CTRL_OFS:  r_d.rdata = {24'h000000, 1'b0, r_q.mem_ack, 1'b0,
                                    r_q.cs_loaded, r_q.priv, 3'h0};
        RHC_STAT_OFS:  r_d.rdata = {21'h000000, r_q.st, r_q.intr_cycle,
                                    r_q.halt, r_q.instr_go, r_q.run_src,
                                    (r_q.run_src && r_q.instr_go),
                                    r_q.adv_block};
        RHC_AR_OFS:    r_d.rdata = lo32(r_q.ar);
        RHC_PC_OFS:    r_d.rdata = {9'h000, r_q.pc};
        RHC_VMA_OFS:   r_d.rdata = {9'h000, r_q.virt_addr_reg};
        RHC_MQ_OFS:    r_d.rdata = lo32(r_q.mq);
        RHC_ARX_OFS:   r_d.rdata = lo32(r_q.arith_ext_reg);
        RHC_IOBUS_OFS: r_d.rdata = lo32(r_q.adder);
        default:       r_d.rdata = 32'h00000000;
      endcase
    end
    if (wr_now) begin
      if (r_q.ad == RHC_CTRL_OFS) begin
        r_d.priv    = hwdata[RHC_CB_PRIV];
        r_d.mem_ack = hwdata[RHC_CB_DEC];
        r_d.io_ack  = hwdata[RHC_CB_IOACK];
        if (hwdata[RHC_CB_LOAD_CS]) begin
          r_d.cs_loaded = 1'b1;
        end
        if (hwdata[RHC_CB_RUN_SET]) begin
          r_d.run_src = 1'b1;
        end
        if (hwdata[RHC_CB_RUN_CLR]) begin
          r_d.run_src = 1'b0;
        end
        if (hwdata[RHC_CB_RESUME]) begin
          r_d.sync_cnt = RHC_SYNC_CYC;
          r_d.instr_go = 1'b1;
        end
        if (hwdata[RHC_CB_HALT_INS] && r_q.priv) begin
          r_d.instr_go = 1'b0;
        end
      end else if (r_q.ad == RHC_AR_OFS) begin
        r_d.ar = {4'h0, hwdata};
      end else if (r_q.ad == RHC_PC_OFS) begin
        r_d.pc = hwdata[RHC_AW-1:0];
      end
    end
    r_d.req = 1'b0;
    unique case (r_q.st)
      RHC_DIAG: begin
        if (r_q.cs_loaded) begin
          r_d.st = RHC_DISPATCH;
        end
      end
      RHC_DISPATCH: begin
        if (intr_req) begin
          r_d.st = RHC_INTR_WAIT;
        end else if (!(r_q.run_src && r_q.instr_go) && !r_q.intr_cycle) begin
          r_d.st = RHC_HALT_ENTER;
        end else begin
          r_d.st   = RHC_FETCH;
          r_d.addr = r_q.pc;
          r_d.exec_process_table  = 1'b0;
          r_d.req  = 1'b1;
        end
        r_d.intr_cycle = 1'b0;
      end
      RHC_HALT_ENTER: begin
        r_d.ar   = '0;
        r_d.halt = 1'b1;
        r_d.pc   = r_q.virt_addr_reg;
        r_d.virt_addr_reg  = r_q.pc;
        r_d.st   = RHC_TIGHT;
      end
      RHC_TIGHT: begin
        if (r_q.sync_cnt != 2'h0) begin
          r_d.halt = 1'b0;
          r_d.adv_block = (r_q.ar != '0);
          if (r_q.ar != '0) begin
            r_d.st = RHC_EXEC;
          end else begin
            r_d.st   = RHC_FETCH;
            r_d.addr = r_q.pc;
            r_d.exec_process_table  = 1'b0;
            r_d.req  = 1'b1;
          end
        end else if (intr_req) begin
          r_d.st = RHC_INTR_WAIT;
        end
      end
      RHC_INTR_WAIT: begin
        r_d.ar = io_bus_in;
        if (r_q.io_ack) begin
          r_d.st = RHC_INTR_DECODE;
        end
      end
      RHC_INTR_DECODE: begin
        r_d.mq         = r_q.ar;
        r_d.fn         = sh_code;
        r_d.intr_cycle = 1'b1;
        r_d.exec_process_table        = 1'b0;
        r_d.addr       = vaddr(r_q.ar);
        r_d.req        = 1'b1;
        r_d.wr         = 1'b0;
        unique case (sh_code)
          RHC_FN_STD0, RHC_FN_STD1: begin
            r_d.addr = RHC_INTR_BASE + {19'h00000, chan, 1'b0};
            r_d.exec_process_table  = 1'b1;
            r_d.st   = RHC_FETCH;
          end
          RHC_FN_DISP:   r_d.st = RHC_FETCH;
          RHC_FN_INCDEC: r_d.st = RHC_RD;
          RHC_FN_DOUT:   r_d.st = RHC_RD;
          RHC_FN_DIN: begin
            r_d.req = 1'b0;
            r_d.st  = RHC_IO_IN;
          end
          RHC_FN_FRONT: begin
            r_d.req = 1'b0;
            r_d.st  = RHC_FRONT;
          end
          default: begin
            r_d.req = 1'b0;
            r_d.st  = RHC_NEXT_REQ;
          end
        endcase
      end
      RHC_FETCH: begin
        r_d.req = !r_q.mem_ack;
        if (r_q.mem_ack) begin
          r_d.arith_ext_reg = mem_rdata;
          r_d.exec_process_table = 1'b0;
          r_d.st  = RHC_EXEC;
        end
      end
      RHC_RD: begin
        r_d.req = !r_q.mem_ack;
        if (r_q.mem_ack) begin
          if (r_q.fn == RHC_FN_INCDEC) begin
            r_d.ar    = r_q.mq[RHC_DEC_BIT] ? mem_rdata - 36'h1
                                            : mem_rdata + 36'h1;
            r_d.wdata = r_d.ar;
            r_d.wr    = 1'b1;
            r_d.req   = 1'b1;
            r_d.st    = RHC_WR;
          end else begin
            r_d.ar = mem_rdata;
            r_d.st = RHC_IO_OUT;
          end
        end
      end
      RHC_WR: begin
        r_d.req = !r_q.mem_ack;
        if (r_q.mem_ack) begin
          r_d.wr = 1'b0;
          r_d.st = RHC_NEXT_REQ;
        end
      end
      RHC_IO_OUT: begin
        r_d.adder = r_q.ar;
        r_d.io_oe = 1'b1;
        if (r_q.io_ack) begin
          r_d.io_oe = 1'b0;
          r_d.st    = RHC_NEXT_REQ;
        end
      end
      RHC_IO_IN: begin
        if (r_q.io_ack) begin
          r_d.ar    = io_bus_in;
          r_d.wdata = io_bus_in;
          r_d.addr  = vaddr(r_q.mq);
          r_d.wr    = 1'b1;
          r_d.req   = 1'b1;
          r_d.st    = RHC_WR;
        end
      end
      RHC_FRONT: begin
        if (r_q.io_ack) begin
          r_d.st = RHC_NEXT_REQ;
        end
      end
      RHC_NEXT_REQ: r_d.st = RHC_NOOP;
      RHC_NOOP: begin
        r_d.intr_cycle = 1'b0;
        r_d.st         = RHC_DISPATCH;
      end
      RHC_EXEC: begin
        if (!r_q.adv_block) begin
          r_d.pc = r_q.pc + 23'h000001;
        end
        r_d.adv_block = 1'b0;
        r_d.ar        = '0;
        r_d.st        = RHC_DISPATCH;
      end
    endcase
    // Reset: control store cleared means diagnostic dispatch
    if (srst) begin
      r_d = '0;
      r_d.st = RHC_DIAG;
    end
  end

  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  // ==========================================================================
  // Outputs
  assign hrdata         = r_q.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign io_bus_out     = r_q.adder;
  assign io_bus_oe      = r_q.io_oe;
  assign mem_req        = r_q.req;
  assign mem_write      = r_q.wr;
  assign mem_exec_table = r_q.exec_process_table;
  assign mem_addr       = r_q.addr;
  assign mem_wdata      = r_q.wdata;
  assign run_state      = r_q.run_src && r_q.instr_go;
  assign continue_sync  = (r_q.sync_cnt != 2'h0);
  assign halt_flag      = r_q.halt;

  // ==========================================================================
  // Assertions
  property p_reset_diag;
    @(posedge clk) srst |=> r_q.st == RHC_DIAG;
  endproperty
  a_reset_diag: assert property (p_reset_diag)
    else $error("reset not diagnostic");

  property p_sync3;
    @(posedge clk) disable iff (srst)
      $rose(continue_sync) |-> continue_sync [*3] ##1 !continue_sync;
  endproperty
  a_sync3: assert property (p_sync3)
    else $error("continue sync length wrong");

  property p_run;
    @(posedge clk) run_state |-> r_q.instr_go && r_q.run_src;
  endproperty
  a_run: assert property (p_run)
    else $error("run state without sources");

  property p_halt_entry;
    @(posedge clk) disable iff (srst)
      r_q.st == RHC_HALT_ENTER |=> halt_flag && r_q.ar == '0
        && r_q.pc == $past(r_q.virt_addr_reg);
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt entry wrong");

  property p_to_halt;
    @(posedge clk) disable iff (srst)
      r_q.st == RHC_DISPATCH && !intr_req && !run_state && !r_q.intr_cycle
        |=> r_q.st == RHC_HALT_ENTER;
  endproperty
  a_to_halt: assert property (p_to_halt)
    else $error("halt loop not entered");

  property p_decode;
    @(posedge clk) disable iff (srst)
      r_q.st == RHC_INTR_WAIT && r_q.io_ack |=> r_q.st == RHC_INTR_DECODE
        ##1 r_q.mq == $past(r_q.ar);
  endproperty
  a_decode: assert property (p_decode)
    else $error("interrupt word not copied");

  property p_std;
    @(posedge clk) disable iff (srst)
      r_q.st == RHC_INTR_DECODE && sh_code == RHC_FN_STD1 |=> mem_exec_table
        && mem_addr == RHC_INTR_BASE + {19'h00000, $past(chan), 1'b0};
  endproperty
  a_std: assert property (p_std)
    else $error("standard address wrong");

  property p_disp;
    @(posedge clk) disable iff (srst)
      r_q.st == RHC_INTR_DECODE && sh_code == RHC_FN_DISP |=> !mem_exec_table;
  endproperty
  a_disp: assert property (p_disp)
    else $error("dispatch used table");

  property p_go_halt;
    @(posedge clk) disable iff (srst)
      $fell(r_q.instr_go) |-> $past(r_q.priv) && r_q.run_src == $past(r_q.run_src);
  endproperty
  a_go_halt: assert property (p_go_halt)
    else $error("halt clear wrong");

  c_halt: cover property (@(posedge clk) r_q.st == RHC_TIGHT);
  c_std:  cover property (@(posedge clk) r_q.st == RHC_FETCH && mem_exec_table);
  c_inc:  cover property (@(posedge clk) r_q.st == RHC_WR);
  c_exec: cover property (@(posedge clk) r_q.st == RHC_EXEC);

endmodule : rhc_core

// >>> testbench/rhc_far_end.sv
module rhc_far_end import rhc_pkg::*; (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control from the bench
  input  wire logic             intr_on,
  input  wire logic             drive_on,
  input  wire logic [RHC_W-1:0] word,
  // Memory side of the core
  input  wire logic             mem_req,
  input  wire logic             mem_write,
  input  wire logic [RHC_AW-1:0] mem_addr,
  // Toward the core
  output logic                  intr_req,
  output logic [RHC_W-1:0]      io_bus_in,
  output logic [RHC_W-1:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [RHC_W-1:0] last_q;
  logic [RHC_W-1:0] rd_q;

  // ==========================================================================
  // Device side of the io bus
  // word held through handshake
  assign intr_req  = intr_on;
  assign io_bus_in = (intr_on | drive_on) ? word : ~last_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      last_q <= '0;
    end else if (intr_on | drive_on) begin
      last_q <= word;
    end
  end

  // ==========================================================================
  // Memory: word is a fixed function of its address
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_q <= '0;
    end else if (mem_req && !mem_write) begin
      rd_q <= {13'h0A5, mem_addr};
    end
  end
  assign mem_rdata = rd_q;
endmodule : rhc_far_end

// >>> testbench/test_run_halt_and_intr_function_ctl.sv
module test_run_halt_and_intr_function_ctl import rhc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk, srst, hsel, hwrite, hreadyout, hresp, p_intr, p_drive;
  logic [31:0]       haddr, hwdata, hrdata, d;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              intr_req, io_bus_oe, mem_req, mem_write, mem_exec_table;
  logic              run_state, continue_sync, halt_flag;
  logic [RHC_W-1:0]  io_bus_in, io_bus_out, mem_rdata, mem_wdata, p_word;
  logic [RHC_AW-1:0] mem_addr, va;
  logic [7:0]        lvl;
  logic [2:0]        ch;
  logic [3:0]        codes [8];
  int                mismatches, check_count, sync_cnt, i;
  integer            seed;

  rhc_core i_rhc_core (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .intr_req(intr_req), .io_bus_in(io_bus_in),
    .io_bus_out(io_bus_out), .io_bus_oe(io_bus_oe), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .mem_write(mem_write),
    .mem_exec_table(mem_exec_table), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .run_state(run_state),
    .continue_sync(continue_sync), .halt_flag(halt_flag));

  rhc_far_end i_rhc_far_end (.clk(clk), .srst(srst), .intr_on(p_intr),
    .drive_on(p_drive), .word(p_word), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .intr_req(intr_req),
    .io_bus_in(io_bus_in), .mem_rdata(mem_rdata));

  // ==========================================================================
  // Clock, watchdog, sync pulse length
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("mismatch at %0t: run limit reached", $time);
    report_and_stop();
  end
  always @(posedge clk) if (continue_sync === 1'b1) sync_cnt++;

  // ==========================================================================
  // Helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [35:0] got, input logic [35:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      mismatches++;
      $display("mismatch at %0t: bus wait timed out", $time);
      report_and_stop();
    end
    chk(36'(hresp), 36'h0, "bus response");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr

  function automatic logic sig(input int k);
    case (k)
      0: return mem_req;
      1: return io_bus_oe;
      default: return halt_flag;
    endcase
  endfunction : sig

  task automatic wait_on(input int k);
    int n;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (sig(k) !== 1'b1 && n < 400);
    if (n >= 400) begin
      mismatches++;
      $display("mismatch at %0t: wait %0d timed out", $time, k);
      report_and_stop();
    end
  endtask : wait_on

  task automatic mem_ack;
    wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h40});
    wr(RHC_CTRL_OFS, {24'h0, lvl});
  endtask : mem_ack

  task automatic mem_srv(input logic w, input logic [22:0] a,
                         input logic [35:0] v, input logic et);
    wait_on(0);
    chk(36'(mem_write), 36'(w), "mem direction");
    chk(36'(mem_addr), 36'(a), "mem address");
    chk(36'(mem_exec_table), 36'(et), "exec table qualifier");
    if (w) chk(mem_wdata, v, "mem write data");
    mem_ack();
  endtask : mem_srv

  task automatic drain;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (mem_req === 1'b1) mem_ack();
    end
  endtask : drain

  function automatic logic [35:0] mword(input logic [22:0] a);
    return {13'h0A5, a};
  endfunction : mword

  task automatic intr(input logic [3:0] code, input logic dn);
    logic [35:0] w, dat;
    logic early;
    w = {code, dn, 5'h0, ch, va};
    dat = {$random(seed), 4'h5};
    early = 1'b0;
    p_word <= w;
    p_intr <= 1'b1;
    for (int n = 0; n < 12; n++) begin @(posedge clk); #1; early |= mem_req; end
    chk(36'(early), 36'h0, "request before handshake");
    wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h80});
    @(posedge clk);
    p_intr <= 1'b0;
    case (code)
      RHC_FN_STD0, RHC_FN_STD1:
        mem_srv(1'b0, RHC_INTR_BASE + 23'(2 * ch), 36'h0, 1'b1);
      RHC_FN_DISP: mem_srv(1'b0, va, 36'h0, 1'b0);
      RHC_FN_INCDEC: begin
        mem_srv(1'b0, va, 36'h0, 1'b0);
        mem_srv(1'b1, va, dn ? mword(va) - 1 : mword(va) + 1, 1'b0);
      end
      RHC_FN_DOUT: begin
        mem_srv(1'b0, va, 36'h0, 1'b0);
        wait_on(1);
        chk(io_bus_out, mword(va), "data out word");
        wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h80});
      end
      RHC_FN_FRONT: begin
        chk(36'(mem_req), 36'h0, "front end used memory");
        wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h80});
      end
      default: begin
        p_word  <= dat;
        p_drive <= 1'b1;
        wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h80});
        @(posedge clk);
        p_drive <= 1'b0;
        mem_srv(1'b1, va, dat, 1'b0);
      end
    endcase
    drain();
    $display("test interrupt code %0d done", code);
  endtask : intr

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h9df8;
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6};
    {hsel, hwrite, p_intr, p_drive, mismatches, check_count, sync_cnt} = '0;
    {haddr, hwdata, htrans, hsize, p_word, lvl} = '0;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(36'({run_state, halt_flag, mem_req, continue_sync, io_bus_oe}),
        36'h0, "outputs before load");
    bus(1'b0, 8'h40, 32'h0, d);
    chk(36'(d), 36'h0, "unmapped read");
    lvl = 8'h10;
    wr(RHC_CTRL_OFS, 32'h30);
    wait_on(2);
    bus(1'b0, RHC_AR_OFS, 32'h0, d);
    chk(36'(d), 36'h0, "arith reg on halt");
    repeat (20) begin @(posedge clk); #1; chk(36'(mem_req), 36'h0, "tight loop"); end
    $display("test reset and halt entry done");
    for (i = 0; i < 8; i++) begin
      ch = (i == 0) ? 3'h7 : 3'(1 + ($unsigned($random(seed)) % 7));
      va = (i == 2) ? 23'h7FFFFF : 23'($random(seed));
      intr(codes[i], i == 4);
      if (i == 0) begin
        bus(1'b0, RHC_MQ_OFS, 32'h0, d);
        chk(36'(d), 36'({1'b0, 5'h0, ch, va}), "mult quot copy");
      end
    end
    bus(1'b0, RHC_PC_OFS, 32'h0, d);
    wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h01});
    chk(36'(run_state), 36'h0, "run without go");
    sync_cnt = 0;
    wr(RHC_CTRL_OFS, {24'h0, lvl | 8'h04});
    mem_srv(1'b0, d[22:0], 36'h0, 1'b0);
    chk(36'(run_state), 36'h1, "run after resume");
    chk(36'(sync_cnt), 36'h3, "sync length");
    lvl = 8'h00;
    wr(RHC_CTRL_OFS, 32'h00);
    wr(RHC_CTRL_OFS, 32'h08);
    drain();
    chk(36'(run_state), 36'h1, "unprivileged halt");
    lvl = 8'h10;
    wr(RHC_CTRL_OFS, 32'h10);
    wr(RHC_CTRL_OFS, 32'h18);
    drain();
    chk(36'({run_state, halt_flag}), 36'h1, "halted");
    bus(1'b0, RHC_STAT_OFS, 32'h0, d);
    chk(36'(d[2]), 36'h1, "run source kept");
    wr(RHC_CTRL_OFS, 32'h12);
    bus(1'b0, RHC_STAT_OFS, 32'h0, d);
    chk(36'(d[2]), 36'h0, "run source cleared");
    $display("test run and halt done");
    wr(RHC_AR_OFS, 32'h0000ABCD);
    sync_cnt = 0;
    wr(RHC_CTRL_OFS, 32'h14);
    drain();
    wait_on(2);
    bus(1'b0, RHC_AR_OFS, 32'h0, d);
    chk(36'(d), 36'h0, "arith reg after single step");
    chk(36'(run_state), 36'h0, "no run after single step");
    chk(36'(sync_cnt), 36'h3, "sync length again");
    $display("test single instruction done");
    report_and_stop();
  end
endmodule : test_run_halt_and_intr_function_ctl
